/* File: design/mac_statistics_counters.sv */
// The APB interface to the registers and the register addresses are this design's own decisions.
`include "mac_stats_params.svh"

module mac_statistics_counters #(
  parameter int SLOT_CYCLES_10M = `SLOT_CYCLES_10M
) (
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [`APB_ADDR_W-1:0]      paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        txDone,
  input  wire mac_stats_pkg::tx_status_t   txStatus,
  input  wire logic                        rxDone,
  input  wire mac_stats_pkg::rx_status_t   rxStatus,
  input  wire logic                        transmitEnableOutputPin,
  input  wire logic                        collisionInputPin,
  output logic      [127:0]                unicastMatchAddressLow,
  output logic                             speed100,
  output logic                             heartbeatCheckEn
);

  localparam int NC = `NUM_COUNTERS;
  localparam int CW [NC] = '{24, 16, 16, 24, 8, 8, 16, 8, 8, 8, 8, 16, 8, 8, 8, 8, 8, 8};

  // counters share one 24-bit array; narrow ones never exceed their own maximum
  logic [`CNT_W-1:0] cnt [NC];
  logic [NC-1:0]     incEvent;

  // bus decode
  wire logic [5:0] regIdx    = paddr[7:2];
  wire logic       apbSetup  = psel && !penable;
  wire logic       apbDone   = psel && penable && pready;
  wire logic       isAddrLow = regIdx <= `REG_ADDR_LOW_LAST;
  wire logic       isCtrl    = regIdx == `REG_CTRL;
  wire logic       isCnt     = regIdx >= `REG_CNT_FIRST && regIdx <= `REG_CNT_LAST;
  wire logic       isMapped  = isAddrLow || isCtrl || isCnt;
  wire logic [4:0] cntSel    = 5'(regIdx - `REG_CNT_FIRST);
  wire logic [1:0] addrSel   = regIdx[1:0];

  // read mux; bits above a counter's width read as zero
  wire logic [31:0] rdMux = isAddrLow ? unicastMatchAddressLow[32*addrSel +: 32]
                          : isCtrl    ? {30'h0, heartbeatCheckEn, speed100}
                          : isCnt     ? {8'h00, cnt[cntSel]}
                          : 32'h0000_0000;

  // answer: pready rises in the first access cycle, read data was taken at setup
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apbSetup;
      pslverr <= apbSetup && !isMapped;
      if (apbSetup) begin
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  // address low and control registers take writes at the completing edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      unicastMatchAddressLow <= 128'h0;
      speed100               <= 1'b0;
      heartbeatCheckEn       <= 1'b1;
    end else if (apbDone && pwrite) begin
      if (isAddrLow) begin
        unicastMatchAddressLow[32*addrSel +: 32] <= pwdata;
      end
      if (isCtrl) begin
        speed100         <= pwdata[`CTRL_SPEED100_BIT];
        heartbeatCheckEn <= pwdata[`CTRL_HB_EN_BIT];
      end
    end
  end

  // transmit classification; an underrun frame feeds only its own counter
  wire mac_stats_pkg::tx_status_t ts = txStatus;
  wire logic txEv    = txDone && !ts.underrun;
  wire logic txLenOk = ts.lengthBytes >= `LEN_MIN_OK && ts.lengthBytes <= `LEN_MAX_OK;
  wire logic txLenMc = ts.lengthBytes >= `LEN_MIN_MCOL && ts.lengthBytes <= `LEN_MAX_OK;
  wire logic multiColl = ts.collisions >= 5'h02 && ts.collisions <= `COLL_MULTI_MAX;

  // a late collision is also in the collision count, so it can feed both counters
  assign incEvent[mac_stats_pkg::CNT_TX_OK] = txEv && ts.sent;
  assign incEvent[mac_stats_pkg::CNT_SCOL]  =
    txEv && ts.sent && ts.collisions == 5'h01 && !ts.carrierLost;
  assign incEvent[mac_stats_pkg::CNT_MCOL]  =
    txEv && ts.sent && multiColl && txLenMc && !ts.carrierLost;
  assign incEvent[mac_stats_pkg::CNT_DEFER] =
    txEv && ts.deferred && ts.collisions == 5'h00;
  assign incEvent[mac_stats_pkg::CNT_LCOL]  =
    txEv && ts.lateCollision && !ts.carrierLost;
  assign incEvent[mac_stats_pkg::CNT_COLLISION_INPUT_PIN]  =
    txEv && ts.excessCollision && txLenOk && !ts.carrierLost;
  assign incEvent[mac_stats_pkg::CNT_TX_UNDR] = txDone && ts.underrun;
  assign incEvent[mac_stats_pkg::CNT_CS_ERR]  =
    txEv && ts.carrierLost && ts.halfDuplex && !ts.excessCollision;

  // receive classification; a matched code-error frame feeds only its own counter
  wire mac_stats_pkg::rx_status_t rs = rxStatus;
  wire logic codeOnly = rs.addrMatch && rs.codeError;
  wire logic rxEv     = rxDone && !codeOnly;
  wire logic rxLenOk  = rs.lengthBytes >= `LEN_MIN_OK && rs.lengthBytes <= `LEN_MAX_OK;
  wire logic rxLong   = rs.lengthBytes > `LEN_MAX_OK;
  wire logic rxShort  = rs.lengthBytes < `LEN_MIN_OK;
  wire logic rxAnyErr = rs.crcBad || rs.codeError;

  assign incEvent[mac_stats_pkg::CNT_RX_OK] =
    rxEv && rs.addrMatch && rxLenOk && !rxAnyErr;
  assign incEvent[mac_stats_pkg::CNT_FCS]   =
    rxEv && rs.addrMatch && rxLenOk && !rs.dribble && rs.crcBad;
  assign incEvent[mac_stats_pkg::CNT_ALIGN] =
    rxEv && rs.addrMatch && rxLenOk && rs.dribble && rs.crcBad;
  assign incEvent[mac_stats_pkg::CNT_RX_DISCARD] =
    rxEv && rs.addrMatch && rs.noBuffer;
  assign incEvent[mac_stats_pkg::CNT_RX_OVR] =
    rxEv && rs.addrMatch && rs.overrun;
  assign incEvent[mac_stats_pkg::CNT_CODE]    = rxDone && codeOnly;
  assign incEvent[mac_stats_pkg::CNT_EXC_LEN] = rxEv && rxLong && !rxAnyErr;
  assign incEvent[mac_stats_pkg::CNT_JABBER]  = rxEv && rxLong && rxAnyErr;
  assign incEvent[mac_stats_pkg::CNT_UNDERSIZE] = rxEv && rxShort && !rxAnyErr;

  // collision pin comes from the PHY, so it is synchronised first
  logic collMeta;
  logic collSync;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      collMeta <= 1'b0;
      collSync <= 1'b0;
    end else begin
      collMeta <= collisionInputPin;
      collSync <= collMeta;
    end
  end

  // heartbeat window: one slot time after transmit enable falls
  localparam int HB_W = 16;
  wire logic [HB_W-1:0] slotCycles = speed100 ? HB_W'(`SLOT_CYCLES_100M)
                                              : HB_W'(SLOT_CYCLES_10M);
  logic            txEnPrev;
  logic            hbArmed;
  logic [HB_W-1:0] hbTimer;
  wire logic txEnFell = txEnPrev && !transmitEnableOutputPin;
  wire logic hbMiss   = hbArmed && !collSync && hbTimer == HB_W'(1);
  assign incEvent[mac_stats_pkg::CNT_HEARTBEAT] = hbMiss;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      txEnPrev <= 1'b0;
      hbArmed  <= 1'b0;
      hbTimer  <= '0;
    end else begin
      txEnPrev <= transmitEnableOutputPin;
      if (txEnFell && heartbeatCheckEn) begin
        hbArmed <= 1'b1;
        hbTimer <= slotCycles;
      end else if (hbArmed) begin
        // a collision pulse inside the window closes it without a count
        hbArmed <= !collSync && hbTimer != HB_W'(1);
        hbTimer <= hbTimer - HB_W'(1);
      end
    end
  end

  // counters: read clear subtracts the value returned, so an event that lands
  // between the setup and access edges is not lost; set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : g_cnt
      localparam logic [`CNT_W-1:0] MAXV = `CNT_W'((25'h1 << CW[gi]) - 25'h1);
      wire logic rdClr = apbDone && !pwrite && isCnt && cntSel == 5'(gi);
      wire logic [`CNT_W-1:0] base = rdClr ? cnt[gi] - prdata[`CNT_W-1:0]
                                           : cnt[gi];
      wire logic [`CNT_W-1:0] next_cnt = (incEvent[gi] && base != MAXV)
                                         ? base + `CNT_W'(1) : base;
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          cnt[gi] <= '0;
        end else begin
          cnt[gi] <= next_cnt;
        end
      end
    end
  endgenerate

  // checks
  chk_pready_access: assert property (@(posedge sys_clk) disable iff (reset)
    (psel && !penable) |=> pready ##1 !pready) else $error("pready timing wrong");

  chk_addr_low_write: assert property (@(posedge sys_clk) disable iff (reset)
    (apbDone && pwrite && regIdx == `REG_ADDR_LOW0)
      |=> unicastMatchAddressLow[31:0] == $past(pwdata)) else $error("address low not written");

  chk_read_clears: assert property (@(posedge sys_clk) disable iff (reset)
    (apbDone && !pwrite && isCnt && cntSel == 5'h00 && !incEvent[0] && $past(!incEvent[0]))
      |=> cnt[0] == 24'h00_0000) else $error("counter not cleared by read");

  chk_sat_hold: assert property (@(posedge sys_clk) disable iff (reset)
    (cnt[16] == 24'h00_00FF && !(apbDone && !pwrite && isCnt && cntSel == 5'h10))
      |=> cnt[16] == 24'h00_00FF) else $error("8-bit counter left saturation");

  chk_tx_ok_count: assert property (@(posedge sys_clk) disable iff (reset)
    (txDone && ts.sent && !ts.underrun && cnt[0] < 24'hFF_FFFF
      && !(apbDone && !pwrite && isCnt))
      |=> cnt[0] == $past(cnt[0]) + 24'h00_0001) else $error("tx ok not counted");

  chk_underrun_alone: assert property (@(posedge sys_clk) disable iff (reset)
    (txDone && ts.underrun) |-> (incEvent & 18'h007C7) == 18'h00200)
    else $error("underrun frame fed other counters");

  chk_code_alone: assert property (@(posedge sys_clk) disable iff (reset)
    (rxDone && rs.addrMatch && rs.codeError && !txDone && !hbMiss)
      |-> incEvent == (18'h1 << mac_stats_pkg::CNT_CODE))
    else $error("code error frame fed other counters");

  chk_hb_arm: assert property (@(posedge sys_clk) disable iff (reset)
    (txEnFell && heartbeatCheckEn) |=> hbArmed && hbTimer == $past(slotCycles))
    else $error("heartbeat window not opened");

  chk_hb_coll_cancel: assert property (@(posedge sys_clk) disable iff (reset)
    (hbArmed && collSync && !txEnFell) |=> !hbArmed ##1 !hbMiss)
    else $error("collision did not close window");

  chk_write_ignored: assert property (@(posedge sys_clk) disable iff (reset)
    (apbDone && pwrite && isCnt && cntSel == 5'h01 && !incEvent[1])
      |=> cnt[1] == $past(cnt[1])) else $error("write changed a counter");

  chk_scol_cause: assert property (@(posedge sys_clk) disable iff (reset)
    (txDone && ts.sent && !ts.underrun && ts.collisions == 5'h01 && !ts.carrierLost)
      |-> incEvent[mac_stats_pkg::CNT_SCOL] && !incEvent[mac_stats_pkg::CNT_MCOL])
    else $error("single collision miscounted");

  // boundary checks: a counter stays quiet outside the frames it is meant for; a late collision with one collision also feeds the single collision counter
  chk_mcol_range: assert property (@(posedge sys_clk) disable iff (reset)
    (txDone && ts.collisions > 5'h0F) |-> !incEvent[2])
    else $error("multi collision counted above fifteen");

  chk_mcol_single: assert property (@(posedge sys_clk) disable iff (reset)
    (txDone && ts.collisions == 5'h01) |-> !incEvent[2])
    else $error("multi collision counted for one collision");

  chk_rx_ok_len: assert property (@(posedge sys_clk) disable iff (reset)
    (rxDone && (rs.lengthBytes < 12'h040 || rs.lengthBytes > 12'h5EE)) |-> !incEvent[3])
    else $error("rx ok counted out of length range");

  chk_rx_ok_err: assert property (@(posedge sys_clk) disable iff (reset)
    (rxDone && (rs.crcBad || rs.codeError)) |-> !incEvent[3])
    else $error("rx ok counted an errored frame");

  chk_fcs_whole: assert property (@(posedge sys_clk) disable iff (reset)
    (rxDone && rs.dribble) |-> !incEvent[4])
    else $error("fcs error counted an odd-bit frame");

  chk_align_odd: assert property (@(posedge sys_clk) disable iff (reset)
    (rxDone && !rs.dribble) |-> !incEvent[5])
    else $error("alignment error counted a whole-byte frame");

  chk_defer_clean: assert property (@(posedge sys_clk) disable iff (reset)
    (txDone && (ts.underrun || ts.collisions != 5'h00)) |-> !incEvent[6])
    else $error("deferral counted with collision or underrun");

  chk_late_twice: assert property (@(posedge sys_clk) disable iff (reset)
    (incEvent[7] && ts.sent && ts.collisions == 5'h01) |-> incEvent[1])
    else $error("late collision not counted as collision");

  chk_excess_only: assert property (@(posedge sys_clk) disable iff (reset)
    (txDone && !ts.excessCollision) |-> !incEvent[8])
    else $error("excess collision counted without sixteen collisions");

  chk_cs_excess: assert property (@(posedge sys_clk) disable iff (reset)
    (txDone && ts.excessCollision) |-> !incEvent[10])
    else $error("carrier error counted with excess collisions");

  chk_discard_match: assert property (@(posedge sys_clk) disable iff (reset)
    (rxDone && !rs.addrMatch) |-> !incEvent[11])
    else $error("discard counted an unmatched frame");

  chk_overrun_match: assert property (@(posedge sys_clk) disable iff (reset)
    (rxDone && !rs.addrMatch) |-> !incEvent[12])
    else $error("overrun counted an unmatched frame");

  chk_long_len: assert property (@(posedge sys_clk) disable iff (reset)
    (rxDone && rs.lengthBytes <= 12'h5EE) |-> !incEvent[14] && !incEvent[15])
    else $error("long frame counter hit by normal length");

  chk_jabber_err: assert property (@(posedge sys_clk) disable iff (reset)
    (rxDone && !rs.crcBad && !rs.codeError) |-> !incEvent[15])
    else $error("jabber counted an error-free frame");

  chk_short_len: assert property (@(posedge sys_clk) disable iff (reset)
    (rxDone && rs.lengthBytes >= 12'h040) |-> !incEvent[16])
    else $error("undersize counted a full frame");

  chk_hb_disabled: assert property (@(posedge sys_clk) disable iff (reset)
    (!heartbeatCheckEn && !hbArmed) |=> !hbArmed)
    else $error("heartbeat window opened while disabled");

  chk_tx_idle: assert property (@(posedge sys_clk) disable iff (reset)
    !txDone |-> (incEvent & 18'h007C7) == 18'h00000)
    else $error("tx counter moved without a frame");

  chk_rx_idle: assert property (@(posedge sys_clk) disable iff (reset)
    !rxDone |-> (incEvent & 18'h1F838) == 18'h00000)
    else $error("rx counter moved without a frame");

  chk_cnt8_bound: assert property (@(posedge sys_clk) disable iff (reset)
    cnt[9] <= 24'h00_00FF && cnt[16] <= 24'h00_00FF)
    else $error("8-bit counter above its maximum");

  chk_cnt16_bound: assert property (@(posedge sys_clk) disable iff (reset)
    cnt[1] <= 24'h00_FFFF && cnt[2] <= 24'h00_FFFF && cnt[6] <= 24'h00_FFFF)
    else $error("16-bit counter above its maximum");

  chk_slverr_pair: assert property (@(posedge sys_clk) disable iff (reset)
    pslverr |-> pready)
    else $error("error answer without ready");

  chk_write_rdata: assert property (@(posedge sys_clk) disable iff (reset)
    (psel && !penable && pwrite) |=> prdata == 32'h0000_0000)
    else $error("write answered with nonzero data");

  chk_cnt_hold: assert property (@(posedge sys_clk) disable iff (reset)
    (!incEvent[0] && !(apbDone && !pwrite && isCnt && cntSel == 5'h00))
      |=> cnt[0] == $past(cnt[0])) else $error("counter moved without cause");

  chk_addr_low_hold: assert property (@(posedge sys_clk) disable iff (reset)
    !(apbDone && pwrite && isAddrLow) |=> $stable(unicastMatchAddressLow))
    else $error("address low changed without a write");

endmodule : mac_statistics_counters

/* File: design/mac_stats_params.svh */
`ifndef MAC_STATS_PARAMS_SVH
`define MAC_STATS_PARAMS_SVH

// register word indices; byte address is four times the index
`define REG_ADDR_LOW0      6'h00
`define REG_ADDR_LOW_LAST  6'h03
`define REG_CTRL           6'h04
`define REG_CNT_FIRST      6'h05
`define REG_CNT_LAST       6'h16
`define APB_ADDR_W         8

// control register fields and reset value
`define CTRL_SPEED100_BIT  0
`define CTRL_HB_EN_BIT     1
`define CTRL_RESET         2'h2

// frame length limits in bytes, and the top collision count for a multiple collision frame
`define LEN_MIN_OK         12'h040
`define LEN_MAX_OK         12'h5EE
`define LEN_MIN_MCOL       12'h03E
`define COLL_MULTI_MAX     5'h0F

// slot time for the heartbeat window
`define SLOT_BITS          512
`define CLK_PERIOD_NS      10
`define BIT_NS_100M        10
`define BIT_NS_10M         100
`define SLOT_CYCLES_100M   (`SLOT_BITS * `BIT_NS_100M / `CLK_PERIOD_NS)
`define SLOT_CYCLES_10M    (`SLOT_BITS * `BIT_NS_10M / `CLK_PERIOD_NS)

`define NUM_COUNTERS       18
`define CNT_W              24

`endif

/* File: design/mac_stats_pkg.sv */
package mac_stats_pkg;

  // counter slots in register order
  typedef enum logic [4:0] {
    CNT_TX_OK      = 5'h00,
    CNT_SCOL       = 5'h01,
    CNT_MCOL       = 5'h02,
    CNT_RX_OK      = 5'h03,
    CNT_FCS        = 5'h04,
    CNT_ALIGN      = 5'h05,
    CNT_DEFER      = 5'h06,
    CNT_LCOL       = 5'h07,
    CNT_COLLISION_INPUT_PIN       = 5'h08,
    CNT_TX_UNDR    = 5'h09,
    CNT_CS_ERR     = 5'h0A,
    CNT_RX_DISCARD = 5'h0B,
    CNT_RX_OVR     = 5'h0C,
    CNT_CODE       = 5'h0D,
    CNT_EXC_LEN    = 5'h0E,
    CNT_JABBER     = 5'h0F,
    CNT_UNDERSIZE  = 5'h10,
    CNT_HEARTBEAT  = 5'h11
  } cnt_idx_t;

  // outcome of one transmitted frame, valid with its done pulse
  typedef struct packed {
    logic        sent;
    logic        underrun;
    logic        deferred;
    logic        lateCollision;
    logic        excessCollision;
    logic        carrierLost;
    logic        halfDuplex;
    logic [4:0]  collisions;
    logic [11:0] lengthBytes;
  } tx_status_t;

  // outcome of one received frame, valid with its done pulse
  typedef struct packed {
    logic        addrMatch;
    logic        dribble;
    logic        crcBad;
    logic        codeError;
    logic        noBuffer;
    logic        overrun;
    logic [11:0] lengthBytes;
  } rx_status_t;

endpackage : mac_stats_pkg

/* File: sim/mac_phy_model.sv */
// far side of the link: transmit enable from the mac engine and the phy collision pin
module mac_phy_model (
  input  wire logic sys_clk,
  output logic      transmitEnableOutputPin,
  output logic      collisionInputPin
);
  timeunit 1ns;
  timeprecision 1ps;

  // both pins idle low; the collision pin has no pull and stays driven low between frames
  initial begin
    transmitEnableOutputPin = 1'b0;
    collisionInputPin = 1'b0;
  end

  // one frame; a heartbeat pulse follows transmit end only when asked for
  task automatic frame(input bit sqe, input int waitCyc);
    transmitEnableOutputPin <= 1'b1;
    repeat (20) @(posedge sys_clk);
    transmitEnableOutputPin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    collisionInputPin <= sqe;
    repeat (3) @(posedge sys_clk);
    collisionInputPin <= 1'b0;
    repeat (waitCyc) @(posedge sys_clk);
  endtask : frame
endmodule : mac_phy_model

/* File: sim/mac_statistics_counters_test.sv */
module mac_statistics_counters_test;
  timeunit 1ns;
  timeprecision 1ps;
  // short 10 Mb/s slot keeps the heartbeat runs brief
  localparam int SLOT10 = 40;
  logic                      sys_clk = 1'b0;
  logic                      reset = 1'b1;
  logic                      psel = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite = 1'b0;
  logic [7:0]                paddr = 8'h00;
  logic [31:0]               pwdata = 32'h0;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      txDone = 1'b0;
  mac_stats_pkg::tx_status_t txStatus = '0;
  logic                      rxDone = 1'b0;
  mac_stats_pkg::rx_status_t rxStatus = '0;
  logic                      transmitEnableOutputPin;
  logic                      collisionInputPin;
  logic [127:0]              unicastMatchAddressLow;
  logic                      speed100;
  logic                      heartbeatCheckEn;
  int                        error_cnt = 0;
  int                        checks_done = 0;
  int                        cycles = 0;
  int                        cnt[18] = '{default: 0};
  int                        wid[18] = '{24, 16, 16, 24, 8, 8, 16, 8, 8, 8, 8, 16, 8, 8, 8, 8, 8, 8};
  int                        txHit[8] = '{0, 1, 2, 6, 7, 8, 9, 10};
  int                        rxHit[9] = '{3, 4, 5, 11, 12, 13, 14, 15, 16};

  mac_statistics_counters #(.SLOT_CYCLES_10M(SLOT10)) uut (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txDone(txDone), .txStatus(txStatus), .rxDone(rxDone), .rxStatus(rxStatus),
    .transmitEnableOutputPin(transmitEnableOutputPin), .collisionInputPin(collisionInputPin),
    .unicastMatchAddressLow(unicastMatchAddressLow), .speed100(speed100),
    .heartbeatCheckEn(heartbeatCheckEn));

  mac_phy_model phy (.sys_clk(sys_clk), .transmitEnableOutputPin(transmitEnableOutputPin),
    .collisionInputPin(collisionInputPin));

  always #5 sys_clk = ~sys_clk;

  // a hang is cut short well past the expected run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // saturating model count: never wraps past all ones
  task automatic bump(input int k);
    if (cnt[k] < (1 << wid[k]) - 1) cnt[k]++;
  endtask : bump

  // psel stays high after a transfer so that a setup may follow at once
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // no fixed latency assumed; only the bench timeout ends a wait
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
  endtask : apb

  task automatic idle();
    psel <= 1'b0;
    @(posedge sys_clk);
  endtask : idle

  task automatic rw(input bit wr, input logic [7:0] a, input logic [31:0] wd,
                    output logic [31:0] rd, output logic err);
    apb(wr, a, wd, rd, err);
    idle();
  endtask : rw

  // back-to-back reads of every counter; each read clears the model too
  task automatic check_all();
    logic [31:0] rd;
    logic        err;
    for (int k = 0; k < 18; k++) begin
      apb(1'b0, 8'(20 + 4 * k), 32'h0, rd, err);
      chk(rd, 32'(cnt[k]));
      cnt[k] = 0;
    end
    idle();
  endtask : check_all

  // transmit outcome kinds: ok, one coll, multi, deferred, late, excess, underrun, carrier
  task automatic mk_tx(input int k, output mac_stats_pkg::tx_status_t s);
    s = '0;
    s.sent = (k != 5);
    s.underrun = (k == 6);
    s.deferred = (k == 3 || k == 6);
    s.lateCollision = (k == 4);
    s.excessCollision = (k == 5);
    s.carrierLost = (k == 7);
    s.halfDuplex = 1'b1;
    s.collisions = (k == 1 || k == 4 || k == 6) ? 5'h01 : (k == 5) ? 5'h10 : 5'h00;
    if (k == 2) s.collisions = 5'($urandom_range(15, 2));
    s.lengthBytes = 12'($urandom_range(1518, (k == 2) ? 62 : 64));
    if (s.sent && !s.underrun) bump(0);
    if (k > 0) bump(txHit[k]);
    if (k == 4) bump(1);
  endtask : mk_tx

  // receive kinds: ok, fcs, align, no buffer, overrun, code, long, jabber, short
  task automatic mk_rx(input int k, output mac_stats_pkg::rx_status_t s);
    s = '0;
    s.addrMatch = (k < 6);
    s.crcBad = (k == 1 || k == 2 || k == 5 || k == 7);
    s.dribble = (k == 2);
    s.noBuffer = (k == 3);
    s.overrun = (k == 4);
    s.codeError = (k == 5);
    s.lengthBytes = 12'($urandom_range(1518, 64));
    if (k >= 5 && k <= 7) s.lengthBytes = 12'($urandom_range(2000, 1519));
    if (k == 8) s.lengthBytes = 12'($urandom_range(63, 20));
    bump(rxHit[k]);
    if (k == 3 || k == 4) bump(3);
  endtask : mk_rx

  // one cycle of frame events; a negative kind means no event
  task automatic ev(input int tk, input int rk);
    mac_stats_pkg::tx_status_t ts;
    mac_stats_pkg::rx_status_t rs;
    ts = '0;
    rs = '0;
    if (tk >= 0) mk_tx(tk, ts);
    if (rk >= 0) mk_rx(rk, rs);
    txDone <= (tk >= 0);
    rxDone <= (rk >= 0);
    txStatus <= ts;
    rxStatus <= rs;
    @(posedge sys_clk);
  endtask : ev

  initial begin
    logic [31:0] rd;
    logic        err;
    logic [31:0] addr[4];
    void'($urandom(32'h50a070df));
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    check_all();
    chk({30'h0, heartbeatCheckEn, speed100}, 32'h2);
    rw(1'b0, 8'h10, 32'h0, rd, err);
    chk(rd, 32'h2);
    for (int i = 0; i < 4; i++) begin
      addr[i] = $urandom;
      rw(1'b1, 8'(4 * i), addr[i], rd, err);
    end
    for (int i = 0; i < 4; i++) begin
      rw(1'b0, 8'(4 * i), 32'h0, rd, err);
      chk(rd, addr[i]);
      chk(unicastMatchAddressLow[32 * i +: 32], addr[i]);
    end
    // unmapped words answer with an error and read as zero
    rw(1'b0, 8'h5C, 32'h0, rd, err);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    rw(1'b1, 8'hFC, 32'hFFFFFFFF, rd, err);
    chk(32'(err), 32'h1);
    for (int k = 0; k < 18; k++) apb(1'b1, 8'(20 + 4 * k), 32'hFFFFFFFF, rd, err);
    idle();
    check_all();
    repeat (300) ev(int'($urandom_range(8)) - 1, int'($urandom_range(9)) - 1);
    ev(-1, -1);
    check_all();
    repeat (260) ev(6, 8);
    ev(-1, -1);
    check_all();
    check_all();
    // heartbeat: missing pulse counts, present pulse or disabled check does not
    phy.frame(1'b0, SLOT10 + 10);
    bump(17);
    phy.frame(1'b1, SLOT10 + 10);
    rw(1'b1, 8'h10, 32'h3, rd, err);
    chk({30'h0, heartbeatCheckEn, speed100}, 32'h3);
    phy.frame(1'b0, 522);
    bump(17);
    rw(1'b1, 8'h10, 32'h1, rd, err);
    phy.frame(1'b0, 522);
    check_all();
    summarize();
  end
endmodule : mac_statistics_counters_test
